// >>> logic/tmc_top.sv
/*
 * Mode control for one 16-bit counter/timer: the two control registers,
 * prescaler, input edge and gate handling, output level with deadband,
 * interrupt source filtering and the capture-cause flag.
 * Assumes the counter itself lives outside and reports reload and PWM
 * match as one-cycle pulses on I_CLK; the timer input pin is asynchronous.
 */
// How it works
// [R01] The mode msb in control zero joins the three mode bits of control one as a 4-bit mode.
// [R02] The interrupt source field passes all events (0x), input events only (10) or reload/compare only (11).
// [R03] Software writes zero to bit 4 of control zero; the block simply stores it.
// [R04] In the PWM modes the deadband field delays each output's rise by 0 cycles for 000, else 2 to the code.
// [R05] The capture-cause flag reads one when the last interrupt came from an input capture.
// [R06] The enable bit stops counting when zero and allows it when one.
// [R07] In one-shot, continuous and compare modes the output equals polarity when off and toggles on reload.
// [R08] Counter mode counts input rising edges for polarity 0, falling for 1, output as one-shot.
// [R09] Single PWM drives polarity when off, its inverse on match and polarity again on reload.
// [R10] Capture mode captures on input rising edges for polarity 0 and falling for 1.
// [R11] Gated mode counts while the input is at its active level and interrupts on its deassertion.
// [R12] Capture/compare starts counting on the first selected edge and captures on each later one.
// [R13] Both control registers reset to zero: disabled, one-shot, no deadband, all interrupts.
// [R14] The prescaler divides by 2 to the divider field and is cleared while the timer is disabled.
// [R15] Mode codes 0 to 10 select the eleven modes in their documented order.
// [R16] In dual PWM the complement is opposite the main output and only rises are delayed.
// [R17] The capture-cause flag is updated at every interrupt taken.
`timescale 1ns/100ps
module tmc_top (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic [11:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   input wire logic I_TIMER_IN,
   input wire logic I_RELOAD,
   input wire logic I_PWM_MATCH,
   output logic O_COUNT_TICK,
   output logic O_CAPTURE,
   output logic O_RESTART,
   output logic O_IRQ,
   output logic O_TIMER_OUT,
   output logic O_TIMER_OUT_N,
   output logic [3:0] O_MODE,
   output logic O_ENABLE
);

   ////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] ctl0_r, ctl0_nxt;
   logic [7:0] ctl1_r, ctl1_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic irq_now, irq_from_cap;

   function automatic logic [7:0] read_mux(input logic [11:0] a, input logic [7:0] c0,
                                           input logic [7:0] c1);
      if (a == tmc_pkg::CTL0_OFFSET) begin
         return c0;
      end else if (a == tmc_pkg::CTL1_OFFSET) begin
         return c1;
      end
      return 8'h00;
   endfunction : read_mux

   always_comb begin
      ctl0_nxt = ctl0_r;
      ctl1_nxt = ctl1_r;
      rdata_nxt = rdata_r;
      if (I_WR && I_ADDR == tmc_pkg::CTL0_OFFSET) begin
         ctl0_nxt = I_WDATA; // R03
      end
      if (I_WR && I_ADDR == tmc_pkg::CTL1_OFFSET) begin
         ctl1_nxt = I_WDATA;
      end
      // The interrupt cause overrides a software write in the same cycle.
      if (irq_now) begin
         ctl0_nxt[tmc_pkg::CAP_FLAG_BIT] = irq_from_cap; // R05 R17
      end
      if (I_RD) begin
         rdata_nxt = read_mux(I_ADDR, ctl0_r, ctl1_r);
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ctl0_r <= tmc_pkg::CTL0_RESET; // R13
         ctl1_r <= tmc_pkg::CTL1_RESET; // R13
         rdata_r <= 8'h00;
      end else begin
         ctl0_r <= ctl0_nxt;
         ctl1_r <= ctl1_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign O_RDATA = rdata_r;

   logic en, pol;
   logic [1:0] irq_sel;
   logic [2:0] dly_sel, div_sel;
   tmc_pkg::tmc_mode_type mode;

   assign mode = tmc_pkg::tmc_mode_type'({ctl0_r[tmc_pkg::MODE_MSB_BIT],
                                          ctl1_r[tmc_pkg::MODE_LOW_LSB +: 3]}); // R01 R15
   assign en = ctl1_r[tmc_pkg::ENABLE_BIT]; // R06
   assign pol = ctl1_r[tmc_pkg::POLARITY_BIT];
   assign irq_sel = ctl0_r[tmc_pkg::IRQ_SEL_LSB +: 2];
   assign dly_sel = ctl0_r[tmc_pkg::DEADBAND_LSB +: 3];
   assign div_sel = ctl1_r[tmc_pkg::DIVIDER_LSB +: 3];
   assign O_MODE = mode;
   assign O_ENABLE = en;

   ////////////////////////////////////////////////////////////////////////////
   // Timer input: two-stage synchroniser, then edge detection.

   logic in_s1_r, in_s2_r, in_d_r;

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         in_s1_r <= 1'b0;
         in_s2_r <= 1'b0;
         in_d_r <= 1'b0;
      end else begin
         in_s1_r <= I_TIMER_IN;
         in_s2_r <= in_s1_r;
         in_d_r <= in_s2_r;
      end
   end

   logic rise, fall, sel_edge, opp_edge, gate_active;
   assign rise = in_s2_r && !in_d_r;
   assign fall = !in_s2_r && in_d_r;
   assign sel_edge = pol ? fall : rise; // R08 R10 R12
   assign opp_edge = pol ? rise : fall; // R11
   assign gate_active = in_s2_r ^ pol; // R11

   ////////////////////////////////////////////////////////////////////////////
   // Count source, capture/compare start and prescaler.

   logic started_r, started_nxt;
   logic [tmc_pkg::PRESCALE_W-1:0] presc_r, presc_nxt, presc_mask;
   logic count_src, capture_evt, deassert_evt;

   always_comb begin
      count_src = en;
      capture_evt = 1'b0;
      deassert_evt = 1'b0;
      case (mode)
         tmc_pkg::MODE_COUNTER: begin
            count_src = en && sel_edge; // R08
         end
         tmc_pkg::MODE_GATED: begin
            count_src = en && gate_active; // R11
            deassert_evt = en && opp_edge; // R11
         end
         tmc_pkg::MODE_CAPTURE, tmc_pkg::MODE_CAPTURE_RESTART: begin
            capture_evt = en && sel_edge; // R10
         end
         tmc_pkg::MODE_CAPTURE_COMPARE: begin
            count_src = en && started_r; // R12
            capture_evt = en && started_r && sel_edge; // R12
         end
         default: begin
            count_src = en;
         end
      endcase
   end

   always_comb begin
      started_nxt = started_r;
      presc_nxt = presc_r;
      if (!en) begin
         started_nxt = 1'b0;
         presc_nxt = '0; // R14
      end else begin
         if (mode == tmc_pkg::MODE_CAPTURE_COMPARE && sel_edge) begin
            started_nxt = 1'b1; // R12
         end
         if (count_src) begin
            presc_nxt = presc_r + 7'h01;
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         started_r <= 1'b0;
         presc_r <= '0;
      end else begin
         started_r <= started_nxt;
         presc_r <= presc_nxt;
      end
   end

   // A tick leaves every 2^div source events; a code of 000 passes each one.
   assign presc_mask = 7'((8'h01 << div_sel) - 8'h01);
   assign O_COUNT_TICK = count_src && ((presc_r & presc_mask) == presc_mask); // R14 R06
   assign O_CAPTURE = capture_evt; // R10 R12
   assign O_RESTART = capture_evt && mode == tmc_pkg::MODE_CAPTURE_RESTART;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt filtering.

   logic reload_evt, input_evt, pass_reload, pass_input;
   assign reload_evt = en && I_RELOAD;
   assign input_evt = capture_evt || deassert_evt;
   assign pass_reload = reload_evt && irq_sel != tmc_pkg::IRQ_INPUT_ONLY; // R02
   assign pass_input = input_evt && irq_sel != tmc_pkg::IRQ_RELOAD_ONLY; // R02
   assign irq_now = pass_reload || pass_input;
   // When a capture and a reload coincide and input events pass, the capture is reported as the cause.
   assign irq_from_cap = pass_input && capture_evt; // R05
   assign O_IRQ = irq_now;

   ////////////////////////////////////////////////////////////////////////////
   // Output level and deadband.

   logic raw_r, raw_nxt, pwm_mode;
   logic [1:0] want, out_r, out_nxt;
   logic [tmc_pkg::DEADBAND_CNT_W-1:0] dcnt_r [2];
   logic [tmc_pkg::DEADBAND_CNT_W-1:0] dcnt_nxt [2];
   logic [tmc_pkg::DEADBAND_CNT_W-1:0] dly;

   assign pwm_mode = mode == tmc_pkg::MODE_PWM_SINGLE || mode == tmc_pkg::MODE_PWM_DUAL;

   always_comb begin
      raw_nxt = raw_r;
      if (!en) begin
         raw_nxt = pol; // R07 R09
      end else if (pwm_mode) begin
         if (I_RELOAD) begin
            raw_nxt = pol; // R09
         end else if (I_PWM_MATCH) begin
            raw_nxt = !pol; // R09
         end
      end else if (I_RELOAD) begin
         raw_nxt = !raw_r; // R07 R08
      end
   end

   // The rise is delayed only while running a PWM mode; idle levels apply at once.
   assign dly = (dly_sel == 3'h0 || !en || !pwm_mode) ? 8'h00 : 8'(8'h01 << dly_sel); // R04
   assign want = {!raw_nxt, raw_nxt}; // R16

   generate
      for (genvar i = 0; i < 2; i++) begin : g_dead
         always_comb begin
            out_nxt[i] = out_r[i];
            dcnt_nxt[i] = dcnt_r[i];
            if (!want[i]) begin
               out_nxt[i] = 1'b0; // R16
               dcnt_nxt[i] = 8'h00;
            end else if (!out_r[i]) begin
               // Reaching or passing the delay releases the rise. A delay that shrinks in
               // mid-count, or drops to zero on disable, would otherwise wrap the counter.
               if (dcnt_r[i] >= dly) begin
                  out_nxt[i] = 1'b1; // R04
               end else begin
                  dcnt_nxt[i] = dcnt_r[i] + 8'h01;
               end
            end
         end

         always_ff @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               out_r[i] <= (i == 1);
               dcnt_r[i] <= 8'h00;
            end else begin
               out_r[i] <= out_nxt[i];
               dcnt_r[i] <= dcnt_nxt[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         raw_r <= 1'b0;
      end else begin
         raw_r <= raw_nxt;
      end
   end

   assign O_TIMER_OUT = out_r[0];
   assign O_TIMER_OUT_N = out_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_read_ctl0: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R13
      I_RD && I_ADDR == tmc_pkg::CTL0_OFFSET |=> O_RDATA == $past(ctl0_r))
      else $error("control zero read data wrong");

   a_irq_reload_only: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R02
      irq_sel == 2'h3 && !reload_evt |-> !O_IRQ)
      else $error("input event passed while reload only");

   a_capture_flag: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R05
      O_IRQ |=> ctl0_r[0] == $past(capture_evt && irq_sel != 2'h3))
      else $error("capture cause flag not updated");

   a_no_tick_off: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R06
      !en |-> !O_COUNT_TICK ##1 presc_r == 7'h00)
      else $error("tick or prescale while disabled");

   a_idle_level: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R07
      !en && !$past(en) |=> O_TIMER_OUT == $past(pol) && O_TIMER_OUT_N == !$past(pol))
      else $error("idle output differs from polarity");

   a_reload_toggle: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R07
      en && I_RELOAD && !I_WR && mode inside {tmc_pkg::MODE_ONE_SHOT,
      tmc_pkg::MODE_CONTINUOUS, tmc_pkg::MODE_COMPARE} |=> raw_r != $past(raw_r))
      else $error("output did not toggle on reload");

   a_gate_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R11
      mode == tmc_pkg::MODE_GATED && !gate_active |-> !O_COUNT_TICK)
      else $error("gated count while input inactive");

   a_deadband_two: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R04
      $rose(raw_r) && en && pwm_mode && dly_sel == 3'h1 && !I_WR && !I_RELOAD
      |-> !O_TIMER_OUT ##1 !O_TIMER_OUT ##1 (O_TIMER_OUT || !raw_r))
      else $error("deadband of two cycles not kept");

   a_dual_overlap: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R16
      !(O_TIMER_OUT && O_TIMER_OUT_N))
      else $error("output and complement high together");

   a_cc_start: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // R12
      mode == tmc_pkg::MODE_CAPTURE_COMPARE && !started_r |-> !O_CAPTURE && !O_COUNT_TICK)
      else $error("capture/compare active before first edge");

endmodule : tmc_top

// >>> logic/tmc_pkg.sv
/*
 * Constants shared by the timer mode control block: register offsets,
 * field positions, reset values and the encoding of the operating modes.
 * Assumes a 12-bit byte address space with 8-bit registers.
 */
package tmc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam logic [11:0] CTL0_OFFSET = 12'hf06;
   localparam logic [11:0] CTL1_OFFSET = 12'hf07;
   localparam logic [7:0] CTL0_RESET = 8'h00;
   localparam logic [7:0] CTL1_RESET = 8'h00;

   // Control register zero.
   localparam int MODE_MSB_BIT = 7;
   localparam int IRQ_SEL_LSB = 5;
   localparam int RESERVED_BIT = 4;
   localparam int DEADBAND_LSB = 1;
   localparam int CAP_FLAG_BIT = 0;

   // Control register one.
   localparam int ENABLE_BIT = 7;
   localparam int POLARITY_BIT = 6;
   localparam int DIVIDER_LSB = 3;
   localparam int MODE_LOW_LSB = 0;

   // Interrupt source selections.
   localparam logic [1:0] IRQ_INPUT_ONLY = 2'h2;
   localparam logic [1:0] IRQ_RELOAD_ONLY = 2'h3;

   localparam int DEADBAND_CNT_W = 8;
   localparam int PRESCALE_W = 7;

   typedef enum logic [3:0] {
      MODE_ONE_SHOT = 4'h0,
      MODE_CONTINUOUS = 4'h1,
      MODE_COUNTER = 4'h2,
      MODE_PWM_SINGLE = 4'h3,
      MODE_CAPTURE = 4'h4,
      MODE_COMPARE = 4'h5,
      MODE_GATED = 4'h6,
      MODE_CAPTURE_COMPARE = 4'h7,
      MODE_PWM_DUAL = 4'h8,
      MODE_CAPTURE_RESTART = 4'h9,
      MODE_COMPARATOR_COUNTER = 4'ha
   } tmc_mode_type;
endpackage : tmc_pkg

// >>> tb/tmc_pin_model.sv
/*
 * Model of the far side of the timer input pin: a source that moves the
 * timer input level, promptly or a few clocks late.
 * Assumes the rising edge of the system clock and a push-pull pin.
 */
`timescale 1ns/100ps
module tmc_pin_model (
   input wire logic i_clk,
   output logic o_pin
);
   initial o_pin = 1'b0;

   // A nonzero delay imitates a slow source, so edges land a few clocks late, always just after a rising clock edge.
   task automatic set(input logic lvl, input int dly);
      repeat (dly + 1) @(posedge i_clk);
      o_pin <= lvl;
   endtask : set
endmodule : tmc_pin_model

// >>> tb/testbench.sv
/*
 * Self-checking testbench for the timer mode control block: registers,
 * modes, event filtering, capture flag, prescaler and deadband.
 * Assumes tmc_top, tmc_pkg and the pin model; reads are checked by a monitor.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench;
   logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
   logic I_RELOAD = 1'b0, I_PWM_MATCH = 1'b0, I_TIMER_IN, rd_q = 1'b0;
   logic [11:0] I_ADDR = 12'h000;
   logic [7:0] I_WDATA = 8'h00, O_RDATA, e_v;
   logic [3:0] O_MODE;
   logic O_COUNT_TICK, O_CAPTURE, O_RESTART, O_IRQ, O_TIMER_OUT, O_TIMER_OUT_N, O_ENABLE;
   logic [7:0] exp_q[$];
   int error_cnt = 0;
   int n_checks = 0;

   always #10 I_CLK = ~I_CLK;

   tmc_top DUT (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_TIMER_IN(I_TIMER_IN),
      .I_RELOAD(I_RELOAD), .I_PWM_MATCH(I_PWM_MATCH), .O_COUNT_TICK(O_COUNT_TICK),
      .O_CAPTURE(O_CAPTURE), .O_RESTART(O_RESTART), .O_IRQ(O_IRQ),
      .O_TIMER_OUT(O_TIMER_OUT), .O_TIMER_OUT_N(O_TIMER_OUT_N), .O_MODE(O_MODE),
      .O_ENABLE(O_ENABLE));
   tmc_pin_model PIN (.i_clk(I_CLK), .o_pin(I_TIMER_IN));

   ////////////////////////////////////////////////////////////////////////////////
   // Read data appear in the cycle after the strobe and hold until the next read; they are taken there.
   always @(posedge I_CLK) begin
      if (rd_q) begin
         e_v = exp_q.pop_front();
         `CHK(O_RDATA, e_v)
      end
      rd_q <= I_RD;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      exp_q.push_back(e);
      @(posedge I_CLK);
      I_RD <= 1'b0;
   endtask : rd

   // The timer is stopped before the mode changes, so no half-written setup runs.
   task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
      wr(tmc_pkg::CTL1_OFFSET, {1'b0, c1[6:0]});
      wr(tmc_pkg::CTL0_OFFSET, c0 & 8'hef);
      wr(tmc_pkg::CTL1_OFFSET, c1);
   endtask : cfg

   task automatic pulse(input logic rld, input logic ei, input logic chk);
      @(posedge I_CLK);
      if (rld) I_RELOAD <= 1'b1;
      else I_PWM_MATCH <= 1'b1;
      @(negedge I_CLK);
      if (chk) `CHK(O_IRQ, ei)
      @(posedge I_CLK);
      I_RELOAD <= 1'b0;
      I_PWM_MATCH <= 1'b0;
   endtask : pulse

   task automatic watch(input int n, output int t, output int c, output int r, output int q);
      t = 0;
      c = 0;
      r = 0;
      q = 0;
      repeat (n) begin
         @(negedge I_CLK);
         t += (O_COUNT_TICK === 1'b1);
         c += (O_CAPTURE === 1'b1);
         r += (O_RESTART === 1'b1);
         q += (O_IRQ === 1'b1);
      end
   endtask : watch

   task automatic step(input logic lvl, output int t, output int c, output int r, output int q);
      PIN.set(lvl, $urandom_range(2));
      watch(8, t, c, r, q);
   endtask : step

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge I_CLK);
      error_cnt++;
      print_verdict();
   end

   initial begin : main
      int t, c, r, q, k;
      static int ml[5] = '{2, 4, 6, 7, 9};
      static int dv[3] = '{0, 2, 7};
      static int db[4] = '{0, 1, 3, 7};
      logic [7:0] c0, c1;
      logic p;
      void'($urandom(32'h4544b583));
      repeat (16) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      rd(tmc_pkg::CTL0_OFFSET, tmc_pkg::CTL0_RESET);
      rd(tmc_pkg::CTL1_OFFSET, tmc_pkg::CTL1_RESET);
      wr(12'hf05, 8'hff);
      rd(12'hf05, 8'h00);
      rd(tmc_pkg::CTL0_OFFSET, 8'h00);
      for (int i = 0; i <= 10; i++) begin
         p = 1'($urandom_range(1));
         c0 = {i[3], 2'($urandom_range(3)), 1'b0, 3'($urandom_range(7)), 1'b0};
         c1 = {1'b0, p, 3'($urandom_range(7)), i[2:0]};
         cfg(c0, c1);
         rd(tmc_pkg::CTL0_OFFSET, c0);
         rd(tmc_pkg::CTL1_OFFSET, c1);
         @(negedge I_CLK);
         `CHK(O_MODE, i[3:0])
         `CHK(O_ENABLE, 1'b0)
         if (i inside {0, 1, 2, 3, 5, 8, 10}) `CHK(O_TIMER_OUT, p)
         if (i inside {3, 8}) `CHK(O_TIMER_OUT_N, ~p)
      end
      for (int s = 0; s < 4; s++) begin
         c0 = {1'b0, 2'(s), 5'h00};
         cfg(c0, 8'h81);
         pulse(1'b1, s != 2, 1'b1);
         @(negedge I_CLK);
         `CHK(O_TIMER_OUT, 1'b1)
         wr(tmc_pkg::CTL1_OFFSET, 8'h84);
         step(1'b1, t, c, r, q);
         `CHK(q, s != 3)
         step(1'b0, t, c, r, q);
         rd(tmc_pkg::CTL0_OFFSET, {c0[7:1], s != 3});
         pulse(1'b1, s != 2, 1'b1);
         rd(tmc_pkg::CTL0_OFFSET, {c0[7:1], s == 2});
      end
      for (int pi = 0; pi < 2; pi++) begin
         p = pi[0];
         foreach (ml[j]) begin
            PIN.set(p, 0);
            cfg({ml[j] == 9, 7'h00}, {1'b1, p, 3'h0, 3'(ml[j])});
            for (int n = 0; n < 3; n++) begin
               step((n == 1) ? p : ~p, t, c, r, q);
               case (ml[j])
                  2: `CHK(t, n != 1)
                  4: `CHK(c, n != 1)
                  6: `CHK(q, n == 1)
                  7: `CHK(c, n == 2)
                  default: `CHK(r, n != 1)
               endcase
            end
         end
      end
      foreach (dv[j]) begin
         cfg(8'h00, {2'b10, 3'(dv[j]), 3'h1});
         watch(256, t, c, r, q);
         `CHK(t, 256 >> dv[j])
         `CHK(O_ENABLE, 1'b1)
      end
      foreach (db[j]) begin
         cfg({4'h0, 3'(db[j]), 1'b0}, 8'h83);
         pulse(1'b0, 1'b0, 1'b0);
         k = 1;
         @(negedge I_CLK);
         while (O_TIMER_OUT !== 1'b1 && k < 300) begin
            @(negedge I_CLK);
            k++;
         end
         `CHK(k, (db[j] == 0) ? 1 : 1 + (1 << db[j]))
         pulse(1'b1, 1'b0, 1'b0);
         @(negedge I_CLK);
         `CHK(O_TIMER_OUT, 1'b0)
      end
      cfg(8'h82, 8'h80);
      pulse(1'b0, 1'b0, 1'b0);
      repeat (4) @(negedge I_CLK);
      `CHK({O_TIMER_OUT, O_TIMER_OUT_N}, 2'b10)
      pulse(1'b1, 1'b0, 1'b0);
      @(negedge I_CLK);
      `CHK({O_TIMER_OUT, O_TIMER_OUT_N}, 2'b00)
      repeat (2) @(negedge I_CLK);
      `CHK(O_TIMER_OUT_N, 1'b1)
      print_verdict();
   end
endmodule : testbench
